/* iac_ctrl.sv */
module iac_ctrl #(
  parameter int          NSRC     = 8,
  parameter int          DEPTH    = 8,
  parameter logic [15:0] VEC_BASE = 16'h0004,
  parameter logic [15:0] NMI_VEC  = 16'h0002
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  input  wire logic [NSRC-1:0]   src_req,
  input  wire logic              nmi_req,
  input  wire logic              seq_boundary,
  input  wire iac_pkg::iac_op_e  seq_op,
  input  wire logic [7:0]        seq_psw_in,
  output      logic [7:0]        psw_out,
  output      logic              ack_valid,
  output      iac_pkg::iac_kind_e ack_kind,
  output      logic [15:0]       ack_vector,
  output      logic [7:0]        ack_psw
);

  localparam int IW = (NSRC > 1) ? $clog2(NSRC) : 1;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]         program_status_word;
    logic [NSRC-1:0]    req;
    logic [NSRC-1:0]    mask;
    logic [NSRC-1:0]    pr;
    logic               nmi_pend;
    logic [DEPTH-1:0]   stk;      // 1 marks a non-maskable level
    logic               hold;
    logic               lp_seen;
    logic               ack_valid;
    iac_pkg::iac_kind_e ack_kind;
    logic [IW-1:0]      ack_idx;
    logic [15:0]        ack_vec;
    logic [7:0]         ack_psw;
    logic               awready;
    logic [7:0]         aw_addr;
    logic               wready;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } iac_state_s;

  iac_state_s s_q;
  iac_state_s s_d;

  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] hi;
  logic [NSRC-1:0] cand;
  logic [IW-1:0]   widx;
  logic            in_nmi;
  logic            hold_op;
  logic            mask_ok;

  // merge a bus write into a register by byte lane
  function automatic logic [31:0] lane_wr(logic [31:0] old,
                                          logic [31:0] wd,
                                          logic [3:0]  st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  // high level sources first, then lowest index; the loop runs down so
  // the last hit is the lowest index
  always_comb begin
    elig = s_q.req & ~s_q.mask;
    hi   = elig & ~s_q.pr;
    cand = (|hi) ? hi : elig;
    widx = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (cand[i]) begin
        widx = IW'(i);
      end
    end
  end

  // any non-maskable level on the in-service stack blocks nested requests; a break still nests
  assign in_nmi = |s_q.stk;

  // instructions after which acceptance waits one more instruction
  assign hold_op = (seq_op == iac_pkg::OP_HOLD) ||
                   (seq_op == iac_pkg::OP_EI) ||
                   (seq_op == iac_pkg::OP_DI) ||
                   (seq_op == iac_pkg::OP_RETURN_FROM_INTERRUPT) ||
                   (seq_op == iac_pkg::OP_RETURN_FROM_BREAK) ||
                   (seq_op == iac_pkg::OP_POP_PSW) ||
                   (seq_op == iac_pkg::OP_PUSH_PSW) ||
                   (seq_op == iac_pkg::OP_WR_PSW);

  // enable, level gate and the extra cycle for a low-level winner
  assign mask_ok = (|cand) && s_q.program_status_word[iac_pkg::PSW_IE] &&
                   (s_q.program_status_word[iac_pkg::PSW_ISP] || !s_q.pr[widx]) &&
                   !in_nmi &&
                   (!s_q.pr[widx] || s_q.lp_seen);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [NSRC-1:0] clr;
    logic [31:0]     tmp;
    logic            hold_now;
    clr      = '0;
    tmp      = '0;
    hold_now = s_q.hold;
    s_d      = s_q;
    s_d.ack_valid = 1'b0;
    s_d.lp_seen   = (|cand) && s_q.pr[widx];

    // write address and data are taken in either order
    if (awvalid && s_q.awready) begin
      s_d.awready = 1'b0;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.wready = 1'b0;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end

    // sequencer boundary: status word ops, then acceptance
    if (seq_boundary) begin
      s_d.hold = 1'b0;
      case (seq_op)
        iac_pkg::OP_EI:
          s_d.program_status_word[iac_pkg::PSW_IE] = 1'b1;
        iac_pkg::OP_DI:
          s_d.program_status_word[iac_pkg::PSW_IE] = 1'b0;
        iac_pkg::OP_RETURN_FROM_INTERRUPT, iac_pkg::OP_RETURN_FROM_BREAK: begin
          s_d.program_status_word = seq_psw_in;
          s_d.stk = s_q.stk >> 1;
        end
        iac_pkg::OP_POP_PSW, iac_pkg::OP_WR_PSW:
          s_d.program_status_word = seq_psw_in;
        default: ;
      endcase
      if (hold_op) begin
        s_d.hold = 1'b1;
      end

      if (seq_op == iac_pkg::OP_BRK) begin
        // break is an instruction, not a request: never masked
        s_d.ack_valid = 1'b1;
        s_d.ack_kind  = iac_pkg::K_BRK;
        s_d.ack_vec   = iac_pkg::BRK_VEC;
        s_d.ack_psw   = s_q.program_status_word;
        s_d.program_status_word[iac_pkg::PSW_IE] = 1'b0;
        s_d.stk = {s_q.stk[DEPTH-2:0], 1'b0};
      end else if (!hold_now && !hold_op) begin
        if (s_q.nmi_pend && !in_nmi) begin
          s_d.ack_valid = 1'b1;
          s_d.ack_kind  = iac_pkg::K_NMI;
          s_d.ack_vec   = NMI_VEC;
          s_d.ack_psw   = s_q.program_status_word;
          s_d.program_status_word[iac_pkg::PSW_IE] = 1'b0;
          s_d.stk = {s_q.stk[DEPTH-2:0], 1'b1};
          s_d.nmi_pend = 1'b0;
        end else if (mask_ok) begin
          s_d.ack_valid = 1'b1;
          s_d.ack_kind  = iac_pkg::K_MASK;
          s_d.ack_idx   = widx;
          s_d.ack_vec   = VEC_BASE + 16'({widx, 1'b0});
          s_d.ack_psw   = s_q.program_status_word;
          s_d.program_status_word[iac_pkg::PSW_IE]  = 1'b0;
          s_d.program_status_word[iac_pkg::PSW_ISP] = s_q.pr[widx];
          s_d.stk = {s_q.stk[DEPTH-2:0], 1'b0};
          clr[widx] = 1'b1;
        end
      end
    end

    // register write once both halves are in
    if (!s_q.awready && !s_q.wready && !s_q.bvalid) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = iac_pkg::RESP_OKAY;
      case (s_q.aw_addr)
        iac_pkg::OFS_PSW: begin
          tmp = lane_wr(32'(s_q.program_status_word), s_q.w_data, s_q.w_strb);
          // the sequencer wins a same-cycle clash so a take still clears
          // the enable flag; the bus write is lost in that cycle
          if (!seq_boundary) begin
            s_d.program_status_word = tmp[7:0];
          end
          s_d.hold = 1'b1;
        end
        iac_pkg::OFS_REQ: begin
          tmp = lane_wr(32'(s_q.req), s_q.w_data, s_q.w_strb);
          s_d.req  = tmp[NSRC-1:0];
          s_d.hold = 1'b1;
        end
        iac_pkg::OFS_MASK: begin
          tmp = lane_wr(32'(s_q.mask), s_q.w_data, s_q.w_strb);
          s_d.mask = tmp[NSRC-1:0];
          s_d.hold = 1'b1;
        end
        iac_pkg::OFS_PRIO: begin
          tmp = lane_wr(32'(s_q.pr), s_q.w_data, s_q.w_strb);
          s_d.pr   = tmp[NSRC-1:0];
          s_d.hold = 1'b1;
        end
        iac_pkg::OFS_STAT: ;                     // read only, write ignored
        default: s_d.bresp = iac_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end

    // register read, one outstanding
    if (arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = iac_pkg::RESP_OKAY;
      s_d.rdata   = '0;
      case (araddr)
        iac_pkg::OFS_PSW:  s_d.rdata[7:0]      = s_q.program_status_word;
        iac_pkg::OFS_REQ:  s_d.rdata[NSRC-1:0] = s_q.req;
        iac_pkg::OFS_MASK: s_d.rdata[NSRC-1:0] = s_q.mask;
        iac_pkg::OFS_PRIO: s_d.rdata[NSRC-1:0] = s_q.pr;
        iac_pkg::OFS_STAT: begin
          s_d.rdata[iac_pkg::ST_NMIP]  = s_q.nmi_pend;
          s_d.rdata[iac_pkg::ST_HOLD]  = s_q.hold;
          s_d.rdata[iac_pkg::ST_INNMI] = in_nmi;
          s_d.rdata[iac_pkg::ST_STK +: DEPTH] = s_q.stk;
        end
        default: s_d.rresp = iac_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end

    // a set arriving with a clear wins; untaken requests stay
    s_d.req      = (s_d.req & ~clr) | src_req;
    s_d.nmi_pend = s_d.nmi_pend | nmi_req;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // mask and priority come up all ones so no maskable source fires before setup
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.program_status_word     <= iac_pkg::PSW_RST;
      s_q.mask    <= {NSRC{iac_pkg::FLAG_SET}};
      s_q.pr      <= {NSRC{iac_pkg::FLAG_SET}};
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign awready    = s_q.awready;
  assign wready     = s_q.wready;
  assign bvalid     = s_q.bvalid;
  assign bresp      = s_q.bresp;
  assign arready    = s_q.arready;
  assign rvalid     = s_q.rvalid;
  assign rdata      = s_q.rdata;
  assign rresp      = s_q.rresp;
  assign psw_out    = s_q.program_status_word;
  assign ack_valid  = s_q.ack_valid;
  assign ack_kind   = s_q.ack_kind;
  assign ack_vector = s_q.ack_vec;
  assign ack_psw    = s_q.ack_psw;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence nmi_ready_s;
    ce && seq_boundary && s_q.nmi_pend && !in_nmi && !s_q.hold &&
      !hold_op && seq_op != iac_pkg::OP_BRK;
  endsequence

  sequence nmi_taken_s;
    s_q.ack_valid && s_q.ack_kind == iac_pkg::K_NMI &&
      s_q.ack_vec == NMI_VEC;
  endsequence

  sequence mask_taken_s;
    s_q.ack_valid && s_q.ack_kind == iac_pkg::K_MASK;
  endsequence

  nmi_take_a: assert property (nmi_ready_s |=> nmi_taken_s)
    else $error("pending non-maskable request not taken");

  nmi_nest_a: assert property (
    s_q.ack_valid && s_q.ack_kind != iac_pkg::K_BRK |->
      !$past(in_nmi))
    else $error("request nested inside non-maskable handler");

  nmi_once_a: assert property (
    nmi_taken_s |-> $past(s_q.nmi_pend) && !s_q.nmi_pend ||
      $past(nmi_req))
    else $error("non-maskable pending flag not consumed");

  // flag vectors are taken from the past and indexed with the new index:
  // a past of an indexed bit would also use the old index
  mask_elig_a: assert property (
    mask_taken_s |->
      |($past(s_q.req & ~s_q.mask) & (NSRC'(1) << s_q.ack_idx)))
    else $error("masked or idle source taken");

  ie_gate_a: assert property (
    mask_taken_s |-> $past(s_q.program_status_word[iac_pkg::PSW_IE]) &&
      ($past(s_q.program_status_word[iac_pkg::PSW_ISP]) ||
       !(|($past(s_q.pr) & (NSRC'(1) << s_q.ack_idx)))))
    else $error("vectored take while disabled or outranked");

  mask_save_a: assert property (
    mask_taken_s |-> !s_q.program_status_word[iac_pkg::PSW_IE] &&
      s_q.program_status_word[iac_pkg::PSW_ISP] ==
        |($past(s_q.pr) & (NSRC'(1) << s_q.ack_idx)) &&
      s_q.ack_psw == $past(s_q.program_status_word))
    else $error("status update on maskable take wrong");

  brk_take_a: assert property (
    ce && seq_boundary && seq_op == iac_pkg::OP_BRK |=>
      s_q.ack_valid && s_q.ack_kind == iac_pkg::K_BRK &&
      s_q.ack_vec == iac_pkg::BRK_VEC && !s_q.program_status_word[iac_pkg::PSW_IE])
    else $error("software break not taken as required");

  // last boundary was a hold instruction; kept apart from the design
  // state so the check does not lean on the hold flag it guards
  logic hold_seen_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_seen_q <= 1'b0;
    end else if (ce && seq_boundary) begin
      hold_seen_q <= hold_op;
    end
  end

  hold_defer_a: assert property (
    ce && seq_boundary && hold_seen_q && seq_op != iac_pkg::OP_BRK |=>
      !s_q.ack_valid)
    else $error("acceptance right after hold instruction");

  ei_set_a: assert property (
    ce && seq_boundary && seq_op == iac_pkg::OP_EI |=>
      s_q.program_status_word[iac_pkg::PSW_IE] ##1 !s_q.ack_valid)
    else $error("unmask_all did not set enable or skip a boundary");

endmodule

/* iac_pkg.sv */
package iac_pkg;

  // ----------------------------------------------------------------
  // status word layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  PSW_RST  = 8'h02;
  localparam int          PSW_IE   = 7;
  localparam int          PSW_ISP  = 1;
  localparam logic        FLAG_SET = 1'b1; // mask and priority flags reset

  // fixed software-break vector entry
  localparam logic [15:0] BRK_VEC  = 16'h003e;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_PSW  = 8'h00;
  localparam logic [7:0]  OFS_REQ  = 8'h04;
  localparam logic [7:0]  OFS_MASK = 8'h08;
  localparam logic [7:0]  OFS_PRIO = 8'h0c;
  localparam logic [7:0]  OFS_STAT = 8'h10;

  // status register bit positions
  localparam int          ST_NMIP  = 0;
  localparam int          ST_HOLD  = 1;
  localparam int          ST_INNMI = 2;
  localparam int          ST_STK   = 8;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // kind of an accepted interrupt
  typedef enum logic [1:0] {K_MASK, K_NMI, K_BRK} iac_kind_e;

  // instruction class reported by the sequencer at each boundary
  typedef enum logic [3:0] {
    OP_NONE, OP_HOLD, OP_EI, OP_DI, OP_BRK, OP_RETURN_FROM_INTERRUPT, OP_RETURN_FROM_BREAK,
    OP_POP_PSW, OP_PUSH_PSW, OP_WR_PSW
  } iac_op_e;

endpackage

/* iac_seq_model.sv */
module iac_seq_model (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               go,
  input  wire iac_pkg::iac_op_e   go_op,
  input  wire logic [7:0]         go_psw,
  input  wire logic               ack_valid,
  input  wire iac_pkg::iac_kind_e ack_kind,
  input  wire logic [7:0]         ack_psw,
  output      logic               seq_boundary,
  output      iac_pkg::iac_op_e   seq_op,
  output      logic [7:0]         seq_psw_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // instruction sequencer stand-in
  // ----------------------------------------------------------------
  logic [9:0] stk_q[$];  // kind and saved status word per level
  logic [9:0] top;

  // one instruction ends per go; a return pops the saved word
  always @(posedge aclk) begin
    if (!aresetn) begin
      stk_q.delete();
      seq_boundary <= 1'b0;
      seq_op       <= iac_pkg::OP_NONE;
      seq_psw_in   <= 8'h00;
    end else begin
      if (ack_valid) stk_q.push_back({ack_kind, ack_psw});
      if (go && go_op == iac_pkg::OP_RETURN_FROM_INTERRUPT) top = stk_q.pop_back();
      else top = {2'b00, go_psw};
      seq_boundary <= go;
      // break handlers leave by the break return, others never
      seq_op <= (go && go_op == iac_pkg::OP_RETURN_FROM_INTERRUPT && top[9:8] == 2'h2) ?
                iac_pkg::OP_RETURN_FROM_BREAK : go_op;
      // outside a boundary the word is stale: drive its inverse
      seq_psw_in <= go ? top[7:0] : ~seq_psw_in;
    end
  end
endmodule

/* testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals and shorthands
  // ----------------------------------------------------------------
  localparam iac_pkg::iac_op_e   NONE = iac_pkg::OP_NONE;
  localparam iac_pkg::iac_op_e   EI   = iac_pkg::OP_EI;
  localparam iac_pkg::iac_op_e   RET  = iac_pkg::OP_RETURN_FROM_INTERRUPT;
  localparam iac_pkg::iac_kind_e KM   = iac_pkg::K_MASK;
  localparam iac_pkg::iac_kind_e KN   = iac_pkg::K_NMI;
  localparam logic [1:0]         OK   = iac_pkg::RESP_OKAY;
  localparam logic [7:0]         MK   = iac_pkg::OFS_MASK;
  localparam logic [7:0]         PR   = iac_pkg::OFS_PRIO;
  localparam logic [15:0]        VB   = 16'h0004;
  localparam logic [15:0]        NV   = 16'h0002;
  logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        nmi_req, go, ack_valid, seq_boundary;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  logic [7:0]  awaddr, araddr, psw_out, ack_psw, seq_psw_in, go_psw;
  logic [7:0]  src_req, exp_psw;
  logic [15:0] ack_vector;
  logic [31:0] wdata, rdata;
  iac_pkg::iac_op_e   go_op, seq_op;
  iac_pkg::iac_kind_e ack_kind;
  int          err_total, cmp_count;
  int unsigned rs = 3;
  logic [7:0]  stk[$];     // expected saved status words
  logic [25:0] exp_q[$];   // expected kind, vector, pushed word

  iac_ctrl #(.NSRC(8), .DEPTH(8), .VEC_BASE(VB), .NMI_VEC(NV)) uut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .src_req(src_req), .nmi_req(nmi_req),
    .seq_boundary(seq_boundary), .seq_op(seq_op),
    .seq_psw_in(seq_psw_in), .psw_out(psw_out), .ack_valid(ack_valid),
    .ack_kind(ack_kind), .ack_vector(ack_vector), .ack_psw(ack_psw)
  );

  iac_seq_model seq (
    .aclk(aclk), .aresetn(aresetn), .go(go), .go_op(go_op),
    .go_psw(go_psw), .ack_valid(ack_valid), .ack_kind(ack_kind),
    .ack_psw(ack_psw), .seq_boundary(seq_boundary), .seq_op(seq_op),
    .seq_psw_in(seq_psw_in)
  );

  // free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    err_total++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic wrap_up;
    $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp_w(input logic [31:0] g, input logic [31:0] e,
                       input string m);
    cmp_count++;
    if (g !== e) fail(m);
  endtask

  task automatic cmp_ack(input logic [25:0] e);
    cmp_count++;
    if ({ack_kind, ack_vector, ack_psw} !== e) fail("accepted interrupt");
  endtask

  function int unsigned xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail("write timeout");
      wrap_up;
    end
    bready <= 1'b0;
    cmp_w(bresp, er, "write response");
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail("read timeout");
      wrap_up;
    end
    rready <= 1'b0;
    cmp_w(rresp, er, "read response");
    if (er == OK) cmp_w(rdata, e, "read data");
    @(posedge aclk);
  endtask

  // one instruction boundary; any expected acceptance must land by now
  task automatic step(input iac_pkg::iac_op_e op);
    if (op == EI) exp_psw[7] = 1'b1;
    if (op == iac_pkg::OP_DI) exp_psw[7] = 1'b0;
    if (op == iac_pkg::OP_POP_PSW) exp_psw = go_psw;
    if (op == RET) exp_psw = stk.pop_back();
    go <= 1'b1;
    go_op <= op;
    @(posedge aclk);
    go <= 1'b0;
    repeat (4) @(posedge aclk);
    cmp_w(psw_out, exp_psw, "status word");
    cmp_w(exp_q.size(), 0, "missing acceptance");
  endtask

  // reference model of one acceptance: saves word, clears enable
  task automatic take(input iac_pkg::iac_kind_e k, input int i,
                      input logic p);
    logic [15:0] v;
    v = (k == KN) ? NV : (k == iac_pkg::K_BRK) ? iac_pkg::BRK_VEC :
        VB + 16'(2 * i);
    exp_q.push_back({k, v, exp_psw});
    stk.push_back(exp_psw);
    exp_psw[7] = 1'b0;
    if (k == KM) exp_psw[1] = p;
  endtask

  task automatic pulse(input logic [7:0] s, input logic n);
    src_req <= s;
    nmi_req <= n;
    @(posedge aclk);
    src_req <= 8'h00;
    nmi_req <= 1'b0;
    @(posedge aclk);
  endtask

  // every acceptance is matched against the model queue
  always @(posedge aclk) begin
    if (aresetn === 1'b1 && ack_valid === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected acceptance");
      else cmp_ack(exp_q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    logic p;
    logic [7:0] pv;
    ce = 1'b1;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, nmi_req, go} = '0;
    {awaddr, araddr, wdata, wstrb, src_req, go_psw} = '0;
    go_op = NONE;
    err_total = 0;
    cmp_count = 0;
    exp_psw = 8'h02;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(iac_pkg::OFS_PSW, 32'h02, OK);
    rd(MK, 32'hff, OK);
    rd(PR, 32'hff, OK);
    rd(8'h20, 32'h0, iac_pkg::RESP_SLVERR);
    wr(8'h24, 32'h0, iac_pkg::RESP_SLVERR);
    wr(iac_pkg::OFS_PSW, 32'h82, OK);
    rd(iac_pkg::OFS_STAT, 32'h2, OK);
    exp_psw = 8'h82;
    step(iac_pkg::OP_DI);
    go_psw = 8'h82;
    step(iac_pkg::OP_POP_PSW);
    step(iac_pkg::OP_PUSH_PSW);
    // random single sources and levels
    for (int k = 0; k < 4; k++) begin
      i = xs() % 8;
      p = 1'(xs());
      pv = 8'hff;
      pv[i] = p;
      wr(MK, 32'hff & ~(32'h1 << i), OK);
      wr(PR, {24'h0, pv}, OK);
      pulse(8'h01 << i, 1'b0);
      step(NONE);
      take(KM, i, p);
      step(NONE);
      step(RET);
      step(NONE);
    end
    // level arbitration and nesting; source 0 stays masked
    wr(MK, 32'h01, OK);
    wr(PR, 32'hfb, OK);
    pulse(8'h07, 1'b0);
    step(NONE);
    take(KM, 2, 1'b0);
    step(NONE);
    step(EI);
    step(NONE);
    step(RET);
    step(NONE);
    take(KM, 1, 1'b1);
    step(NONE);
    step(EI);
    step(NONE);
    pulse(8'h0c, 1'b0);
    take(KM, 2, 1'b0);
    step(NONE);
    step(RET);
    step(NONE);
    take(KM, 3, 1'b1);
    step(NONE);
    for (int k = 0; k < 2; k++) begin
      step(RET);
      step(NONE);
    end
    pulse(8'h60, 1'b0);
    take(KM, 5, 1'b1);
    step(NONE);
    step(RET);
    step(NONE);
    take(KM, 6, 1'b1);
    step(NONE);
    step(RET);
    step(NONE);
    // non-maskable service with nested break
    step(iac_pkg::OP_DI);
    step(NONE);
    pulse(8'h00, 1'b1);
    take(KN, 0, 1'b0);
    step(NONE);
    rd(iac_pkg::OFS_STAT, 32'h104, OK);
    step(EI);
    pulse(8'h08, 1'b1);
    pulse(8'h00, 1'b1);
    step(NONE);
    take(iac_pkg::K_BRK, 0, 1'b0);
    step(iac_pkg::OP_BRK);
    step(RET);
    step(RET);
    step(NONE);
    take(KN, 0, 1'b0);
    step(NONE);
    step(RET);
    step(NONE);
    step(NONE);
    step(EI);
    step(NONE);
    take(KM, 3, 1'b1);
    step(NONE);
    step(RET);
    wr(MK, 32'h00, OK);
    step(NONE);
    take(KM, 0, 1'b1);
    step(NONE);
    wrap_up;
  end
endmodule
